// ===== verilog/tpw_map.svh
// Register offsets, field positions, reset values and counts of the triggered pulse timer.
`ifndef TPW_MAP_SVH
`define TPW_MAP_SVH

// =====================================================================
// Register offsets (byte addresses)
`define TPW_OFS_CTRL 8'h00
`define TPW_OFS_CYCLE 8'h04
`define TPW_OFS_WIDTH 8'h08
`define TPW_OFS_COUNT 8'h0C
`define TPW_OFS_STATUS 8'h10

// =====================================================================
// Control register fields
`define TPW_CTRL_RUN_BIT 0
`define TPW_CTRL_SWTRIG_BIT 1
`define TPW_CTRL_EDGE_LSB 2
`define TPW_CTRL_EDGE_MSB 3
`define TPW_CTRL_PRESC_LSB 4
`define TPW_CTRL_PRESC_MSB 6

// =====================================================================
// Status register fields
`define TPW_STAT_STATE_LSB 0
`define TPW_STAT_STATE_MSB 1
`define TPW_STAT_PULSE_BIT 2
`define TPW_STAT_RELOAD_BIT 3

// =====================================================================
// Reset values and counter constants
`define TPW_RST_CTRL 16'h0000
`define TPW_RST_CYCLE 16'hFFFF
`define TPW_RST_WIDTH 16'h0000
`define TPW_CNT_ZERO 16'h0000
`define TPW_CNT_FULL 16'hFFFF

// =====================================================================
// Trigger edge selection codes
`define TPW_EDGE_NONE 2'h0
`define TPW_EDGE_RISE 2'h1
`define TPW_EDGE_FALL 2'h2
`define TPW_EDGE_BOTH 2'h3

`endif

// ===== verilog/tpw_pkg.sv
// Types shared by the triggered pulse timer files.
`default_nettype none
package tpw_pkg;

  // =====================================================================
  // Timer states
  typedef enum logic [1:0] {
    TPW_IDLE,
    TPW_WAIT,
    TPW_COUNT
  } tpw_state_t;

  // =====================================================================
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tpw_bus_req_t;

  // =====================================================================
  // Control register contents
  typedef struct packed {
    logic [2:0] presc;
    logic [1:0] edge_sel;
    logic run;
  } tpw_ctrl_t;

  // =====================================================================
  // Qualified edges from the trigger pin
  typedef struct packed {
    logic rise;
    logic fall;
  } tpw_edges_t;

endpackage : tpw_pkg
`default_nettype wire

// ===== verilog/tpw_trig_sync.sv
// Three-stage synchroniser and edge detector for the trigger input pin.
`timescale 1ns/100ps
`default_nettype none
module tpw_trig_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output tpw_pkg::tpw_edges_t edges_o
);
  import tpw_pkg::*;

  logic ff1_reg;
  logic ff2_reg;
  logic ff3_reg;
  logic level_reg;
  tpw_edges_t edges_reg;

  // =====================================================================
  // Synchroniser chain
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ff1_reg <= 1'b0;
      ff2_reg <= 1'b0;
      ff3_reg <= 1'b0;
    end else begin
      ff1_reg <= pin_i;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
    end
  end

  // =====================================================================
  // Edge detection
  // A change is accepted only once two later stages agree, so a level
  // that settles in the first stage never produces a spurious edge.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 1'b0;
      edges_reg <= '0;
    end else begin
      edges_reg <= '0;
      if ((ff2_reg == ff3_reg) && (ff2_reg != level_reg)) begin
        level_reg <= ff2_reg;
        edges_reg.rise <= ff2_reg;
        edges_reg.fall <= ~ff2_reg;
      end
    end
  end

  assign edges_o = edges_reg;

endmodule : tpw_trig_sync
`default_nettype wire

// ===== verilog/tpw_timer.sv
// Triggered pulse output timer: 16-bit counter, compare shadows and pulse output.
//
// Summary of operation
// - Counter read returns live count, undisturbed.
// - Period is cycle plus one; active equals width.
// - Width write arms shadow reload at next clear.
// - Width zero: always inactive, both matches together.
// - Width equals cycle plus one: always active.
// - Trigger after width match restarts, asserts output.
// - Trigger before width match suppresses it.
// - Trigger after cycle match extends active time.
// - Trigger before cycle match suppresses it.
// - Width match raised when counter equals width.
// - Run bit enters trigger wait, counter held.
// - Pin edge or software bit acts as trigger.
// - Running trigger clears counter, output goes active.
// - Cycle match raised on count after equality.
//
// Added by the designer: the placing of the registers and the strobed register port.
`include "tpw_map.svh"
`timescale 1ns/100ps
`default_nettype none
module tpw_timer (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire tpw_pkg::tpw_bus_req_t bus_req_i,
  output logic [15:0] rdata_o,
  input wire logic trigger_input_pin_i,
  output logic pulse_output_pin_o,
  output logic half_rate_output_pin_o,
  output logic cycle_match_irq_o,
  output logic width_match_irq_o
);
  import tpw_pkg::*;

  tpw_ctrl_t ctrl_reg;
  logic [15:0] cycle_compare_reg;
  logic [15:0] width_compare_reg;
  logic [15:0] sh_cycle_reg;
  logic [15:0] sh_width_reg;
  logic reload_pend_reg;
  logic trig_pend_reg;
  logic [6:0] div_reg;
  logic tick_reg;
  tpw_state_t st_reg;
  tpw_state_t st_next;
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic pulse_reg;
  logic pulse_next;
  logic half_reg;
  logic half_next;
  logic cyc_irq_reg;
  logic cyc_irq_next;
  logic wid_irq_reg;
  logic wid_irq_next;
  logic [15:0] rdata_reg;
  logic clr;
  logic do_load;
  logic [15:0] new_width;
  logic [15:0] cnt_inc;
  logic fire;
  logic sw_trig;
  logic pin_trig;
  tpw_edges_t edges;

  // =====================================================================
  // Helper functions
  function automatic logic [6:0] presc_limit(input logic [2:0] sel);
    presc_limit = 7'(({7'd0, 1'b1} << sel) - 8'd1);
  endfunction : presc_limit

  function automatic logic bus_hit(input tpw_bus_req_t req, input logic [7:0] ofs);
    bus_hit = (req.addr == ofs);
  endfunction : bus_hit

  // =====================================================================
  // Trigger pin front end
  tpw_trig_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(trigger_input_pin_i),
    .edges_o(edges)
  );

  assign pin_trig = (edges.rise && ctrl_reg.edge_sel[0]) || (edges.fall && ctrl_reg.edge_sel[1]);
  assign sw_trig = bus_req_i.wr && bus_hit(bus_req_i, `TPW_OFS_CTRL) &&
                   bus_req_i.wdata[`TPW_CTRL_SWTRIG_BIT] && ctrl_reg.run;
  assign fire = tick_reg && trig_pend_reg;

  // =====================================================================
  // Register writes
  // The prescale and edge fields may be changed while running; the
  // divider compares with the new limit from the next clock, wrapping at once if already past it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_reg <= tpw_ctrl_t'(6'(`TPW_RST_CTRL));
      cycle_compare_reg <= `TPW_RST_CYCLE;
      width_compare_reg <= `TPW_RST_WIDTH;
    end else if (bus_req_i.wr) begin
      if (bus_hit(bus_req_i, `TPW_OFS_CTRL)) begin
        ctrl_reg.run <= bus_req_i.wdata[`TPW_CTRL_RUN_BIT];
        ctrl_reg.edge_sel <= bus_req_i.wdata[`TPW_CTRL_EDGE_MSB:`TPW_CTRL_EDGE_LSB];
        ctrl_reg.presc <= bus_req_i.wdata[`TPW_CTRL_PRESC_MSB:`TPW_CTRL_PRESC_LSB];
      end
      if (bus_hit(bus_req_i, `TPW_OFS_CYCLE)) begin
        cycle_compare_reg <= bus_req_i.wdata;
      end
      if (bus_hit(bus_req_i, `TPW_OFS_WIDTH)) begin
        width_compare_reg <= bus_req_i.wdata;
      end
    end
  end

  // =====================================================================
  // Register reads: data stand only in the cycle after the strobe.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (bus_req_i.rd) begin
      unique case (bus_req_i.addr)
        `TPW_OFS_CTRL: rdata_reg <= {9'h000, ctrl_reg.presc, ctrl_reg.edge_sel, 1'b0, ctrl_reg.run};
        `TPW_OFS_CYCLE: rdata_reg <= cycle_compare_reg;
        `TPW_OFS_WIDTH: rdata_reg <= width_compare_reg;
        `TPW_OFS_COUNT: rdata_reg <= cnt_reg;
        `TPW_OFS_STATUS: rdata_reg <= {12'h000, reload_pend_reg, pulse_reg, st_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // =====================================================================
  // Count clock divider
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (!ctrl_reg.run) begin
      div_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else if (div_reg >= presc_limit(ctrl_reg.presc)) begin
      div_reg <= 7'h00;
      tick_reg <= 1'b1;
    end else begin
      div_reg <= div_reg + 7'h01;
      tick_reg <= 1'b0;
    end
  end

  // =====================================================================
  // Pending trigger: an event arriving on the consuming tick is kept.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trig_pend_reg <= 1'b0;
    end else if (!ctrl_reg.run) begin
      trig_pend_reg <= 1'b0;
    end else begin
      trig_pend_reg <= pin_trig || sw_trig || (trig_pend_reg && !tick_reg);
    end
  end

  // =====================================================================
  // Counter, state and output sequencing
  assign cnt_inc = cnt_reg + 16'h0001;

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    pulse_next = pulse_reg;
    half_next = half_reg;
    cyc_irq_next = 1'b0;
    wid_irq_next = 1'b0;
    clr = 1'b0;
    do_load = 1'b0;
    new_width = sh_width_reg;
    if (!ctrl_reg.run) begin
      st_next = TPW_IDLE;
      cnt_next = `TPW_CNT_ZERO;
      pulse_next = 1'b0;
    end else if (st_reg == TPW_IDLE) begin
      st_next = TPW_WAIT;
      cnt_next = `TPW_CNT_FULL;
      do_load = 1'b1;
    end else if (tick_reg) begin
      unique case (st_reg)
        TPW_WAIT: begin
          if (fire) begin
            st_next = TPW_COUNT;
            clr = 1'b1;
          end
        end
        TPW_COUNT: begin
          if (fire) begin
            clr = 1'b1;
          end else if (cnt_reg == sh_cycle_reg) begin
            // cycle match on the following count
            clr = 1'b1;
            cyc_irq_next = 1'b1;
          end else begin
            cnt_next = cnt_inc;
            // width match with the output edge
            if (cnt_inc == sh_width_reg) begin
              pulse_next = 1'b0;
              wid_irq_next = 1'b1;
            end
          end
        end
        default: begin
          st_next = TPW_IDLE;
        end
      endcase
      if (clr) begin
        cnt_next = `TPW_CNT_ZERO;
        half_next = ~half_reg;
        do_load = reload_pend_reg;
        new_width = reload_pend_reg ? width_compare_reg : sh_width_reg;
        // zero width matches at the clear itself
        pulse_next = (new_width != `TPW_CNT_ZERO);
        wid_irq_next = (new_width == `TPW_CNT_ZERO);
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= TPW_IDLE;
      cnt_reg <= `TPW_CNT_ZERO;
      pulse_reg <= 1'b0;
      half_reg <= 1'b0;
      cyc_irq_reg <= 1'b0;
      wid_irq_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
      half_reg <= half_next;
      cyc_irq_reg <= cyc_irq_next;
      wid_irq_reg <= wid_irq_next;
    end
  end

  // =====================================================================
  // Shadow compare buffers
  // reload at run start, and at a counter clear after a width write
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_cycle_reg <= `TPW_RST_CYCLE;
      sh_width_reg <= `TPW_RST_WIDTH;
    end else if (do_load) begin
      sh_cycle_reg <= cycle_compare_reg;
      sh_width_reg <= width_compare_reg;
    end
  end

  // A width write landing on the reload cycle stays armed for the next
  // clear, since the value loaded this cycle is the older one.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reload_pend_reg <= 1'b0;
    end else if (bus_req_i.wr && bus_hit(bus_req_i, `TPW_OFS_WIDTH)) begin
      reload_pend_reg <= 1'b1;
    end else if (do_load) begin
      reload_pend_reg <= 1'b0;
    end
  end

  assign rdata_o = rdata_reg;
  assign pulse_output_pin_o = pulse_reg;
  assign half_rate_output_pin_o = half_reg;
  assign cycle_match_irq_o = cyc_irq_reg;
  assign width_match_irq_o = wid_irq_reg;

  // =====================================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_count_rd;
    bus_req_i.rd && bus_hit(bus_req_i, `TPW_OFS_COUNT);
  endsequence

  property p_count_read;
    logic [15:0] v;
    (s_count_rd, v = cnt_reg) |=> (rdata_o == v);
  endproperty
  a_count_read: assert property (p_count_read) else $error("count read mismatch");

  property p_width_match;
    width_match_irq_o |-> (cnt_reg == sh_width_reg) && !pulse_output_pin_o;
  endproperty
  a_width_match: assert property (p_width_match) else $error("width match misaligned");

  property p_cycle_match;
    cycle_match_irq_o |-> (cnt_reg == 16'h0000) && ($past(cnt_reg) == $past(sh_cycle_reg));
  endproperty
  a_cycle_match: assert property (p_cycle_match) else $error("cycle match misaligned");

  property p_trig_clear;
    (fire && ctrl_reg.run && st_reg == TPW_COUNT) |=> (cnt_reg == 16'h0000) && !cycle_match_irq_o &&
      (pulse_output_pin_o == (sh_width_reg != 16'h0000));
  endproperty
  a_trig_clear: assert property (p_trig_clear) else $error("trigger clear wrong");

  property p_trig_before_width;
    (fire && ctrl_reg.run && st_reg == TPW_COUNT && cnt_inc == sh_width_reg && !reload_pend_reg &&
      sh_width_reg != 16'h0000)
      |=> !width_match_irq_o && pulse_output_pin_o;
  endproperty
  a_trig_before_width: assert property (p_trig_before_width) else $error("width match not suppressed");

  property p_trig_before_cycle;
    (fire && ctrl_reg.run && st_reg == TPW_COUNT && cnt_reg == sh_cycle_reg) |=> !cycle_match_irq_o;
  endproperty
  a_trig_before_cycle: assert property (p_trig_before_cycle) else $error("cycle match not suppressed");

  sequence s_run_start;
    st_reg == TPW_IDLE && ctrl_reg.run;
  endsequence

  property p_wait_hold;
    s_run_start |=> (st_reg == TPW_WAIT) && (cnt_reg == 16'hFFFF) && !pulse_output_pin_o;
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("trigger wait entry wrong");

  property p_shadow_load;
    !$stable(sh_width_reg) |-> $past(reload_pend_reg) || $past(st_reg == TPW_IDLE);
  endproperty
  a_shadow_load: assert property (p_shadow_load) else $error("shadow loaded without width write");

  property p_pulse_rise;
    $rose(pulse_output_pin_o) |-> (cnt_reg == 16'h0000);
  endproperty
  a_pulse_rise: assert property (p_pulse_rise) else $error("output set away from clear");

  sequence s_sw_trig;
    sw_trig && !tick_reg;
  endsequence

  property p_sw_trig;
    s_sw_trig |=> trig_pend_reg;
  endproperty
  a_sw_trig: assert property (p_sw_trig) else $error("software trigger lost");

  property p_zero_width;
    (cyc_irq_reg && sh_width_reg == 16'h0000) |-> width_match_irq_o && !pulse_output_pin_o;
  endproperty
  a_zero_width: assert property (p_zero_width) else $error("zero width not inactive");

endmodule : tpw_timer
`default_nettype wire

// ===== tb/tpw_trig_src.sv
// Trigger source model that drives the trigger pin with clean pulses.
`timescale 1ns/100ps
`default_nettype none
module tpw_trig_src (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic fire_i,
  output logic trig_pin_o
);
  logic [2:0] hold_reg;

  // =====================================================================
  // Pulse generation
  // The pin stays high for several clocks so that the synchroniser sees both edges.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_reg <= 3'h0;
    end else if (fire_i) begin
      hold_reg <= 3'h6;
    end else if (hold_reg != 3'h0) begin
      hold_reg <= hold_reg - 3'h1;
    end
  end

  assign trig_pin_o = (hold_reg != 3'h0);
endmodule : tpw_trig_src
`default_nettype wire

// ===== tb/triggered_pwm_timer_mode_tb_top.sv
// Self-checking testbench of the triggered pulse timer.
`timescale 1ns/100ps
`default_nettype none
`include "tpw_map.svh"
module triggered_pwm_timer_mode_tb_top;
  import tpw_pkg::*;
  logic ref_clk, rst_n, fire, trig_pin, pulse, half, cyc_irq, wid_irq;
  tpw_bus_req_t req;
  logic [15:0] rdata;
  logic [15:0] rd_val;
  logic [15:0] first_cnt;
  int num_errors = 0;
  int cmp_count = 0;

  tpw_timer dut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .bus_req_i(req), .rdata_o(rdata),
    .trigger_input_pin_i(trig_pin), .pulse_output_pin_o(pulse), .half_rate_output_pin_o(half),
    .cycle_match_irq_o(cyc_irq), .width_match_irq_o(wid_irq));
  tpw_trig_src src (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .fire_i(fire), .trig_pin_o(trig_pin));

  // =====================================================================
  // Shared tasks
  task automatic give_verdict();
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask : bus_wr

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 rd_val = rdata;
    check(rd_val & m, exp, "register read");
  endtask : rd_chk

  // Waits for the next cycle match; a missing match ends the run.
  task automatic wait_cyc(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1 n++;
      if (n > lim) begin
        num_errors++;
        $display("[FAIL] %0t no cycle match", $time);
        give_verdict();
      end
    end while (cyc_irq !== 1'b1);
  endtask : wait_cyc

  // Measures one full period that starts at the next cycle match.
  task automatic measure(input int per, input int hi, input int nw);
    int p, h, w;
    logic hs;
    wait_cyc(300);
    p = 0;
    h = 0;
    w = 0;
    hs = half;
    do begin
      p++;
      h += int'(pulse);
      w += int'(wid_irq && !pulse);
      @(posedge ref_clk);
      #1;
    end while (cyc_irq !== 1'b1 && p < 300);
    check(16'(p), 16'(per), "period length");
    check(16'(h), 16'(hi), "active length");
    check(16'(w), 16'(nw), "width matches at output fall");
    check({15'h0000, half}, {15'h0000, ~hs}, "half rate toggle");
  endtask : measure

  // =====================================================================
  // Scenarios
  task automatic reset_values();
    rd_chk(`TPW_OFS_CTRL, 16'h0000, 16'hFFFF);
    rd_chk(`TPW_OFS_CYCLE, 16'hFFFF, 16'hFFFF);
    rd_chk(`TPW_OFS_WIDTH, 16'h0000, 16'hFFFF);
    rd_chk(8'h14, 16'h0000, 16'hFFFF);
    rd_chk(`TPW_OFS_STATUS, 16'h0000, 16'h0007);
  endtask : reset_values

  task automatic start_and_shape();
    bus_wr(`TPW_OFS_CYCLE, 16'h0003);
    bus_wr(`TPW_OFS_WIDTH, 16'h0002);
    bus_wr(`TPW_OFS_CTRL, 16'h0005);
    repeat (5) @(posedge ref_clk);
    rd_chk(`TPW_OFS_STATUS, 16'h0001, 16'h0003);
    rd_chk(`TPW_OFS_COUNT, 16'hFFFF, 16'hFFFF);
    bus_wr(`TPW_OFS_CTRL, 16'h0007);
    measure(4, 2, 1);
  endtask : start_and_shape

  task automatic reload_order();
    bus_wr(`TPW_OFS_CYCLE, 16'h0005);
    measure(4, 2, 1);
    bus_wr(`TPW_OFS_WIDTH, 16'h0002);
    measure(6, 2, 1);
    bus_wr(`TPW_OFS_CYCLE, 16'h0007);
    bus_wr(`TPW_OFS_WIDTH, 16'h0005);
    measure(8, 5, 1);
    bus_wr(`TPW_OFS_WIDTH, 16'h0001);
    measure(8, 1, 1);
  endtask : reload_order

  task automatic zero_full_duty();
    bus_wr(`TPW_OFS_WIDTH, 16'h0000);
    measure(8, 0, 1);
    check({15'h0000, wid_irq}, 16'h0001, "both matches together");
    bus_wr(`TPW_OFS_WIDTH, 16'h0008);
    measure(8, 8, 0);
  endtask : zero_full_duty

  task automatic retrigger();
    int n;
    bus_wr(`TPW_OFS_CYCLE, 16'h00FF);
    bus_wr(`TPW_OFS_WIDTH, 16'h0010);
    wait_cyc(50);
    for (n = 0; n < 40 && wid_irq !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check({15'h0000, wid_irq}, 16'h0001, "width match seen");
    rd_chk(`TPW_OFS_COUNT, 16'h0011, 16'hFFFF);
    first_cnt = rd_val;
    rd_chk(`TPW_OFS_COUNT, first_cnt + 16'h0002, 16'hFFFF);
    @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    for (n = 0; n < 12 && pulse !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check({15'h0000, pulse}, 16'h0001, "pin trigger asserts output");
    rd_chk(`TPW_OFS_COUNT, 16'h0000, 16'hFFF0);
    // The software trigger is timed to land one count before the width match.
    repeat (11) @(posedge ref_clk);
    bus_wr(`TPW_OFS_CTRL, 16'h0007);
    n = 0;
    while (pulse === 1'b1 && n < 100) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    check({15'h0000, n >= 16 && n <= 19}, 16'h0001, "active time lengthened");
  endtask : retrigger

  // A software trigger timed onto the last count of the period.
  task automatic cycle_race();
    bus_wr(`TPW_OFS_CYCLE, 16'h0003);
    bus_wr(`TPW_OFS_WIDTH, 16'h0002);
    wait_cyc(300);
    @(posedge ref_clk);
    bus_wr(`TPW_OFS_CTRL, 16'h0007);
    @(posedge ref_clk);
    #1;
    check({cyc_irq, pulse, 14'h0000}, 16'h4000, "cycle match not suppressed");
    wait_cyc(8);
    check({15'h0000, pulse}, 16'h0001, "output active after clear");
  endtask : cycle_race

  task automatic run_stop();
    bus_wr(`TPW_OFS_CTRL, 16'h0000);
    repeat (3) @(posedge ref_clk);
    rd_chk(`TPW_OFS_STATUS, 16'h0000, 16'h0007);
  endtask : run_stop

  // =====================================================================
  // Clock, reset and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  initial begin
    rst_n = 1'b0;
    fire = 1'b0;
    req = '0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    reset_values();
    start_and_shape();
    reload_order();
    zero_full_duty();
    retrigger();
    cycle_race();
    run_stop();
    give_verdict();
  end
endmodule : triggered_pwm_timer_mode_tb_top
`default_nettype wire
